// File: hw/fcid_regs.v
// Summary of operation
// [RULE1] flash control set accepts only whole-word access, bit operations refused
// [RULE2] control set decoded on fast bus, temporary unprotect word on extension bus
// [RULE3] four identity words at F078h..F07Eh in extended special-function space
// [RULE4] identity words are read-only; writes never change them
// [RULE5] device identity word: device code high, silicon revision in low nibble
// [RULE6] memory capacity code is kilobytes over four, 040h for 256 kilobytes
// [RULE7] memory kind code 0..3 as listed, 4..F reserved; this part reports 3h
// [RULE8] programming supply code in low byte, 40h for five volts
// [RULE9] programming identity high byte reads 00h, no external voltage needed
// [RULE10] identity contents guaranteed only after flash initialisation finishes
// [RULE11] external access pin high at reset: identity valid from the start; code sets completion on the first clock after reset release
// [RULE12] external access pin low: top two memory bits drop when initialisation ends
// [RULE13] before initialisation memory word reads F040h, programming word 0040h
// [RULE14] data registers reset to FFFFh; control, address, fault, unprotect to 0000h
// [RULE15] access guard 0 resets to ACFFh; guard 1 halves and write guard to FFFFh
// [RULE16] identity writes complete normally, no error, value unchanged
`timescale 1ns/1ns
`default_nettype none
`include "fcid_consts.vh"

module fcid_regs
#(
    parameter [10:0] MAKER_CODE  = 11'h155, // arbitrary value
    parameter [11:0] DEVICE_CODE = 12'h2a5, // arbitrary value
    parameter [3:0]  REVISION    = 4'h1
)
(
    // clock and reset
    input  wire        mclk,
    input  wire        sys_rst,
    // straps and flash controller status
    input  wire        externalAccessPin,
    input  wire        flashInitDone,
    input  wire [15:0] faultSet,
    // internal fast bus
    input  wire        fbReq,
    input  wire        fbWrite,
    input  wire [23:0] fbAddr,
    input  wire [1:0]  fbByteEn,
    input  wire        fbBitOp,
    input  wire [15:0] fbWdata,
    output reg  [15:0] fbRdata_q,
    output reg         fbAck_q,
    output reg         fbErr_q,
    // extension bus
    input  wire        xbReq,
    input  wire        xbWrite,
    input  wire [15:0] xbAddr,
    input  wire [15:0] xbWdata,
    output reg  [15:0] xbRdata_q,
    output reg         xbAck_q,
    // extended special-function space
    input  wire        esReq,
    input  wire        esWrite,
    input  wire [15:0] esAddr,
    output reg  [15:0] esRdata_q,
    output reg         esAck_q,
    // register contents toward the flash controller
    output wire [16*`FCID_NREGS-1:0] flashRegs,
    output reg  [15:0] tempUnprotect_q,
    output reg         initComplete_q
);

    function [3:0] fbIndex;
        input [23:0] a;
        begin
            case (a)
                `FCID_A_CTL0_LO:  fbIndex = `FCID_I_CTL0_LO;
                `FCID_A_CTL0_HI:  fbIndex = `FCID_I_CTL0_HI;
                `FCID_A_CTL1_LO:  fbIndex = `FCID_I_CTL1_LO;
                `FCID_A_CTL1_HI:  fbIndex = `FCID_I_CTL1_HI;
                `FCID_A_DAT0_LO:  fbIndex = `FCID_I_DAT0_LO;
                `FCID_A_DAT0_HI:  fbIndex = `FCID_I_DAT0_HI;
                `FCID_A_DAT1_LO:  fbIndex = `FCID_I_DAT1_LO;
                `FCID_A_DAT1_HI:  fbIndex = `FCID_I_DAT1_HI;
                `FCID_A_ADR_LO:   fbIndex = `FCID_I_ADR_LO;
                `FCID_A_ADR_HI:   fbIndex = `FCID_I_ADR_HI;
                `FCID_A_FAULT:    fbIndex = `FCID_I_FAULT;
                `FCID_A_NVWG:     fbIndex = `FCID_I_NVWG;
                `FCID_A_NVAG0:    fbIndex = `FCID_I_NVAG0;
                `FCID_A_NVAG1_LO: fbIndex = `FCID_I_NVAG1_LO;
                `FCID_A_NVAG1_HI: fbIndex = `FCID_I_NVAG1_HI;
                default:          fbIndex = `FCID_I_NONE;
            endcase
        end
    endfunction

    function [15:0] resetValue;
        input [3:0] i;
        begin
            case (i)
                `FCID_I_DAT0_LO, `FCID_I_DAT0_HI,
                `FCID_I_DAT1_LO, `FCID_I_DAT1_HI,
                `FCID_I_NVWG, `FCID_I_NVAG1_LO,
                `FCID_I_NVAG1_HI: resetValue = `FCID_RST_ONES;   // [RULE14] [RULE15]
                `FCID_I_NVAG0:    resetValue = `FCID_RST_NVAG0;  // [RULE15]
                default:          resetValue = `FCID_RST_ZERO;   // [RULE14]
            endcase
        end
    endfunction

    // fast bus access qualification
    wire [3:0] fbIdx       = fbIndex(fbAddr);                   // [RULE2]
    wire       fbWholeWord = (fbByteEn == 2'b11) && !fbBitOp;   // [RULE1]
    wire       fbHit       = (fbIdx != `FCID_I_NONE);
    wire       fbWrOk      = fbReq && fbWrite && fbWholeWord && fbHit;

    reg  [15:0]               bank_q [0:`FCID_NREGS-1];
    wire [16*`FCID_NREGS-1:0] bankNext;
    integer                   i;

    // one process owns the whole array, so each slot has a single driver
    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (i = 0; i < `FCID_NREGS; i = i + 1)
                bank_q[i] <= resetValue(i[3:0]);   // [RULE14] [RULE15]
        end
        else
        begin
            for (i = 0; i < `FCID_NREGS; i = i + 1)
                bank_q[i] <= bankNext[16*i +: 16];
        end
    end

    genvar g;
    generate
        for (g = 0; g < `FCID_NREGS; g = g + 1)
        begin : gBank
            localparam [3:0] IDX = g;
            wire [15:0] stored = bank_q[g];
            wire        wrHere = fbWrOk && (fbIdx == IDX);
            reg  [15:0] bank_d;
            always @*
            begin
                bank_d = wrHere ? fbWdata : stored;
                // hardware fault set wins over a software clear in the same cycle
                if (IDX == `FCID_I_FAULT)
                    bank_d = bank_d | faultSet;
            end
            assign bankNext[16*g+15:16*g]  = bank_d;
            assign flashRegs[16*g+15:16*g] = stored;
        end
    endgenerate

    // fast bus answer: one cycle after the request
    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            fbRdata_q <= 16'h0000;
            fbAck_q   <= 1'b0;
            fbErr_q   <= 1'b0;
        end
        else
        begin
            fbAck_q   <= fbReq;
            fbErr_q   <= fbReq && !(fbWholeWord && fbHit);   // [RULE1]
            fbRdata_q <= (fbReq && !fbWrite && fbWholeWord && fbHit)
                         ? bank_q[fbIdx] : 16'h0000;
        end
    end

    // extension bus: temporary unprotect word only
    wire xbHit = (xbAddr == `FCID_A_TMP_UNPROT);   // [RULE2]

    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tempUnprotect_q <= `FCID_RST_ZERO;   // [RULE14]
            xbRdata_q       <= 16'h0000;
            xbAck_q         <= 1'b0;
        end
        else
        begin
            if (xbReq && xbWrite && xbHit)
                tempUnprotect_q <= xbWdata;
            xbAck_q   <= xbReq;
            xbRdata_q <= (xbReq && !xbWrite && xbHit) ? tempUnprotect_q : 16'h0000;
        end
    end

    // strap capture: the pin is taken in the first cycle after reset release,
    // since an asynchronously reset flop may not load a port value
    reg strapTaken_q;
    reg strapHigh_q;

    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            strapTaken_q <= 1'b0;
            strapHigh_q  <= 1'b0;
        end
        else if (!strapTaken_q)
        begin
            strapTaken_q <= 1'b1;
            strapHigh_q  <= externalAccessPin;
        end
    end

    // completion is sticky; controller done or internal-boot strap ends the wait
    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            initComplete_q <= 1'b0;
        else if (flashInitDone)
            initComplete_q <= 1'b1;                            // [RULE10] [RULE12]
        else if (!strapTaken_q && externalAccessPin)
            initComplete_q <= 1'b1;                            // [RULE11]
    end

    // identity words, composed from constants and the completion flag
    wire [15:0] idMaker = {MAKER_CODE, `FCID_MAKER_TAIL};
    wire [15:0] idDev   = {DEVICE_CODE, REVISION};                    // [RULE5]
    wire [3:0]  memKind = initComplete_q ? `FCID_MEMKIND_HPF
                                         : `FCID_MEMKIND_BUSY;        // [RULE7] [RULE12] [RULE13]
    wire [15:0] memory_identity_word   = {memKind, `FCID_MEMCAP_CODE};               // [RULE6]
    wire [15:0] programming_identity_word  = {`FCID_PROG_EXTVPP, `FCID_PROG_SUPPLY};     // [RULE8] [RULE9] [RULE13]

    reg [15:0] esSel;
    always @*
    begin
        case (esAddr)                                                 // [RULE3]
            `FCID_A_ID_PROG:  esSel = programming_identity_word;
            `FCID_A_ID_MEM:   esSel = memory_identity_word;
            `FCID_A_ID_DEV:   esSel = idDev;
            `FCID_A_ID_MAKER: esSel = idMaker;
            default:          esSel = 16'h0000;
        endcase
    end

    // writes are acknowledged and dropped; no storage exists to alter
    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            esRdata_q <= 16'h0000;
            esAck_q   <= 1'b0;
        end
        else
        begin
            esAck_q   <= esReq;                                       // [RULE16]
            esRdata_q <= (esReq && !esWrite) ? esSel : 16'h0000;      // [RULE4]
        end
    end

endmodule

`default_nettype wire

// File: inc/fcid_consts.vh
`ifndef FCID_CONSTS_VH
`define FCID_CONSTS_VH

// internal fast bus byte addresses of the flash control set
`define FCID_A_CTL0_LO    24'h080000
`define FCID_A_CTL0_HI    24'h080002
`define FCID_A_CTL1_LO    24'h080004
`define FCID_A_CTL1_HI    24'h080006
`define FCID_A_DAT0_LO    24'h080008
`define FCID_A_DAT0_HI    24'h08000a
`define FCID_A_DAT1_LO    24'h08000c
`define FCID_A_DAT1_HI    24'h08000e
`define FCID_A_ADR_LO     24'h080010
`define FCID_A_ADR_HI     24'h080012
`define FCID_A_FAULT      24'h080014
`define FCID_A_NVWG       24'h08dfb0
`define FCID_A_NVAG0      24'h08dfb8
`define FCID_A_NVAG1_LO   24'h08dfbc
`define FCID_A_NVAG1_HI   24'h08dfbe

// register slot indices in the fast bus bank
`define FCID_I_CTL0_LO    4'h0
`define FCID_I_CTL0_HI    4'h1
`define FCID_I_CTL1_LO    4'h2
`define FCID_I_CTL1_HI    4'h3
`define FCID_I_DAT0_LO    4'h4
`define FCID_I_DAT0_HI    4'h5
`define FCID_I_DAT1_LO    4'h6
`define FCID_I_DAT1_HI    4'h7
`define FCID_I_ADR_LO     4'h8
`define FCID_I_ADR_HI     4'h9
`define FCID_I_FAULT      4'ha
`define FCID_I_NVWG       4'hb
`define FCID_I_NVAG0      4'hc
`define FCID_I_NVAG1_LO   4'hd
`define FCID_I_NVAG1_HI   4'he
`define FCID_I_NONE       4'hf
`define FCID_NREGS        15

// extension bus address
`define FCID_A_TMP_UNPROT 16'heb50

// extended special-function space word addresses
`define FCID_A_ID_PROG    16'hf078
`define FCID_A_ID_MEM     16'hf07a
`define FCID_A_ID_DEV     16'hf07c
`define FCID_A_ID_MAKER   16'hf07e

// reset values
`define FCID_RST_ZERO     16'h0000
`define FCID_RST_ONES     16'hffff
`define FCID_RST_NVAG0    16'hacff

// identity word fields
`define FCID_MAKER_TAIL   5'h03
`define FCID_MEMKIND_HPF  4'h3
`define FCID_MEMKIND_BUSY 4'hf
`define FCID_MEMCAP_CODE  12'h040
`define FCID_PROG_SUPPLY  8'h40
`define FCID_PROG_EXTVPP  8'h00

`endif

// File: testbench/fcid_regs_props.sv
`timescale 1ns/1ns
`default_nettype none
module fcid_regs_props (
    // clock and reset
    input wire logic         mclk,
    input wire logic         sys_rst,
    // strap and status
    input wire logic         externalAccessPin,
    input wire logic         initComplete_q,
    input wire logic [15:0]  tempUnprotect_q,
    input wire logic [239:0] flashRegs,
    // fast bus
    input wire logic         fbReq,
    input wire logic         fbWrite,
    input wire logic [23:0]  fbAddr,
    input wire logic [1:0]   fbByteEn,
    input wire logic         fbBitOp,
    input wire logic [15:0]  fbWdata,
    input wire logic [15:0]  fbRdata_q,
    input wire logic         fbAck_q,
    input wire logic         fbErr_q,
    // extension bus and identity space
    input wire logic         xbReq,
    input wire logic         xbWrite,
    input wire logic [15:0]  xbAddr,
    input wire logic         esReq,
    input wire logic         esWrite,
    input wire logic [15:0]  esAddr,
    input wire logic [15:0]  esRdata_q,
    input wire logic         esAck_q
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    chk_fb_ack: assert property (fbReq |=> fbAck_q)
        else $error("fast bus request not acknowledged");
    chk_bitop_refused: assert property (fbReq && fbBitOp |=> fbErr_q && fbRdata_q == 16'h0000)
        else $error("bit access not refused");
    chk_partial_refused: assert property (fbReq && fbByteEn != 2'b11 |=> fbErr_q)
        else $error("partial access not refused");
    chk_addr_write: assert property (fbReq && fbWrite && !fbBitOp && fbByteEn == 2'b11
        && fbAddr == 24'h080010 |=> flashRegs[143:128] == $past(fbWdata))
        else $error("address low word not written");
    chk_unprot_hold: assert property (!(xbReq && xbWrite && xbAddr == 16'heb50)
        |=> $stable(tempUnprotect_q))
        else $error("unprotect word changed without write");
    chk_prog_word: assert property (esReq && !esWrite && esAddr == 16'hf078
        |=> esRdata_q == 16'h0040)
        else $error("programming word wrong");
    chk_mem_busy: assert property (esReq && !esWrite && esAddr == 16'hf07a && !initComplete_q
        |=> esRdata_q == 16'hf040)
        else $error("memory word wrong before init");
    chk_mem_ready: assert property (esReq && !esWrite && esAddr == 16'hf07a && initComplete_q
        |=> esRdata_q == 16'h3040)
        else $error("memory word wrong after init");
    chk_strap_boot: assert property ($past(sys_rst) && externalAccessPin |=> initComplete_q)
        else $error("strap high boot not complete");
    chk_id_ack: assert property (esReq |=> esAck_q)
        else $error("identity access not acknowledged");
endmodule
bind fcid_regs fcid_regs_props u_props (.mclk(mclk), .sys_rst(sys_rst),
    .externalAccessPin(externalAccessPin), .initComplete_q(initComplete_q),
    .tempUnprotect_q(tempUnprotect_q), .flashRegs(flashRegs), .fbReq(fbReq),
    .fbWrite(fbWrite), .fbAddr(fbAddr), .fbByteEn(fbByteEn), .fbBitOp(fbBitOp),
    .fbWdata(fbWdata), .fbRdata_q(fbRdata_q), .fbAck_q(fbAck_q), .fbErr_q(fbErr_q),
    .xbReq(xbReq), .xbWrite(xbWrite), .xbAddr(xbAddr), .esReq(esReq),
    .esWrite(esWrite), .esAddr(esAddr), .esRdata_q(esRdata_q), .esAck_q(esAck_q));
`default_nettype wire

// File: testbench/tb_flash_control_and_identification_regs.sv
`timescale 1ns/1ns
`default_nettype none
module tb_flash_control_and_identification_regs;
    logic        mclk, sys_rst, externalAccessPin, flashInitDone;
    logic        fbReq, fbWrite, fbBitOp, fbAck_q, fbErr_q;
    logic [23:0] fbAddr;
    logic [1:0]  fbByteEn;
    logic [15:0] fbWdata, fbRdata_q, xbAddr, xbWdata, xbRdata_q, esAddr, esRdata_q;
    logic        xbReq, xbWrite, xbAck_q, esReq, esWrite, esAck_q, initComplete_q;
    logic [15:0] tempUnprotect_q, faultSet;
    logic [239:0] flashRegs;
    int          errorCnt = 0;
    int          samplesChecked = 0;
    localparam logic [23:0] GUARD [0:3] = '{24'h08dfb0, 24'h08dfb8, 24'h08dfbc, 24'h08dfbe};

    fcid_regs dut (.mclk(mclk), .sys_rst(sys_rst), .externalAccessPin(externalAccessPin),
        .flashInitDone(flashInitDone), .faultSet(faultSet), .fbReq(fbReq), .fbWrite(fbWrite),
        .fbAddr(fbAddr), .fbByteEn(fbByteEn), .fbBitOp(fbBitOp), .fbWdata(fbWdata),
        .fbRdata_q(fbRdata_q), .fbAck_q(fbAck_q), .fbErr_q(fbErr_q), .xbReq(xbReq),
        .xbWrite(xbWrite), .xbAddr(xbAddr), .xbWdata(xbWdata), .xbRdata_q(xbRdata_q),
        .xbAck_q(xbAck_q), .esReq(esReq), .esWrite(esWrite), .esAddr(esAddr),
        .esRdata_q(esRdata_q), .esAck_q(esAck_q), .flashRegs(flashRegs),
        .tempUnprotect_q(tempUnprotect_q), .initComplete_q(initComplete_q));

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    function automatic logic [23:0] slotAddr(input int i);
        return i < 11 ? 24'h080000 + 24'(2 * i) : GUARD[i - 11];
    endfunction

    function automatic logic [15:0] rstVal(input int i);
        return i inside {[4:7], 11, 13, 14} ? 16'hffff : i == 12 ? 16'hacff : 16'h0000;
    endfunction

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        samplesChecked++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic endOfTest;
        $display("comparisons %0d mismatches %0d", samplesChecked, errorCnt);
        if (errorCnt == 0 && samplesChecked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic doReset(input logic strap);
        externalAccessPin <= strap;
        sys_rst <= 1'b1;
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
    endtask

    // b selects fast bus 0, extension bus 1, identity space 2
    task automatic bus(input int b, input logic wr, input logic [23:0] a, input logic [15:0] d,
        input logic [1:0] be, input logic bo, input logic [15:0] expD, input logic expE);
        logic [1:0]  ack;
        logic [15:0] rd;
        {fbReq, xbReq, esReq} <= 3'b100 >> b;
        {fbWrite, xbWrite, esWrite} <= {3{wr}};
        fbAddr <= a;
        xbAddr <= a[15:0];
        esAddr <= a[15:0];
        fbWdata <= d;
        xbWdata <= d;
        fbByteEn <= be;
        fbBitOp <= bo;
        @(posedge mclk);
        {fbReq, xbReq, esReq} <= 3'b000;
        #1;
        ack = b == 0 ? {fbAck_q, fbErr_q} : {b == 1 ? xbAck_q : esAck_q, 1'b0};
        rd = b == 0 ? fbRdata_q : b == 1 ? xbRdata_q : esRdata_q;
        chk("ack and error", {14'h0, 1'b1, expE}, {14'h0, ack});
        if (!wr)
            chk("read data", expD, rd);
        @(posedge mclk);
    endtask

    task automatic tIdent(input logic [15:0] memWord);
        bus(2, 0, 24'hf07a, 0, 3, 0, memWord, 0);
        bus(2, 0, 24'hf078, 0, 3, 0, 16'h0040, 0);
        bus(2, 0, 24'hf07c, 0, 3, 0, {12'h2a5, 4'h1}, 0);
        bus(2, 0, 24'hf07e, 0, 3, 0, {11'h155, 5'h03}, 0);
    endtask

    task automatic tReset;
        for (int i = 0; i < 15; i++)
        begin
            chk("reset slot", rstVal(i), flashRegs[16 * i +: 16]);
            bus(0, 0, slotAddr(i), 0, 3, 0, rstVal(i), 0);
        end
        chk("unprotect reset", 16'h0000, tempUnprotect_q);
        tIdent(16'hf040);
        $display("reset values done");
    endtask

    task automatic tRw;
        for (int i = 0; i < 15; i++)
            bus(0, 1, slotAddr(i), 16'h5a00 + 16'(i), 3, 0, 0, 0);
        for (int i = 0; i < 15; i++)
            bus(0, 0, slotAddr(i), 0, 3, 0, 16'h5a00 + 16'(i), 0);
        $display("fast bus access done");
    endtask

    task automatic tRefuse;
        bus(0, 1, 24'h080010, 16'h0bad, 3, 1, 0, 1);
        bus(0, 1, 24'h080010, 16'h0bad, 1, 0, 0, 1);
        bus(0, 0, 24'h080010, 0, 3, 1, 0, 1);
        bus(0, 0, 24'h080010, 0, 3, 0, 16'h5a08, 0);
        bus(0, 0, 24'h080016, 0, 3, 0, 0, 1);
        $display("refused access done");
    endtask

    task automatic tXb;
        bus(1, 1, 24'heb50, 16'ha5c3, 3, 0, 0, 0);
        chk("unprotect word", 16'ha5c3, tempUnprotect_q);
        bus(1, 1, 24'heb52, 16'h5555, 3, 0, 0, 0);
        bus(1, 0, 24'heb50, 0, 3, 0, 16'ha5c3, 0);
        bus(1, 0, 24'heb52, 0, 3, 0, 16'h0000, 0);
        bus(0, 0, 24'h00eb50, 0, 3, 0, 0, 1);
        $display("extension bus done");
    endtask

    task automatic tIdWrite;
        for (int i = 0; i < 4; i++)
            bus(2, 1, 24'hf078 + 24'(2 * i), 16'h0000, 3, 0, 0, 0);
        tIdent(16'hf040);
        $display("identity write done");
    endtask

    // hardware fault set must win over a software clear in the same cycle
    task automatic tFault;
        faultSet <= 16'h0010;
        bus(0, 1, 24'h080014, 16'h0000, 3, 0, 0, 0);
        faultSet <= 16'h0000;
        bus(0, 0, 24'h080014, 0, 3, 0, 16'h0010, 0);
        bus(0, 1, 24'h080014, 16'h0000, 3, 0, 0, 0);
        bus(0, 0, 24'h080014, 0, 3, 0, 16'h0000, 0);
        $display("fault word done");
    endtask

    task automatic tInit;
        flashInitDone <= 1'b1;
        @(posedge mclk);
        flashInitDone <= 1'b0;
        @(posedge mclk);
        tIdent(16'h3040);
        doReset(1'b1);
        tIdent(16'h3040);
        chk("address slot", 16'h0000, flashRegs[143:128]);
        $display("init and strap done");
    endtask

    initial
    begin
        {sys_rst, externalAccessPin, flashInitDone} = 3'b100;
        {fbReq, fbWrite, fbBitOp, xbReq, xbWrite, esReq, esWrite} = 7'h00;
        {fbAddr, fbByteEn, fbWdata, xbAddr, xbWdata, esAddr, faultSet} = '0;
        doReset(1'b0);
        tReset();
        tRw();
        tRefuse();
        tXb();
        tIdWrite();
        tFault();
        tInit();
        endOfTest();
    end

    // whole run needs about 190 cycles
    initial
    begin
        repeat (3000) @(posedge mclk);
        errorCnt++;
        $display("watchdog expired");
        endOfTest();
    end
endmodule
`default_nettype wire
